// ==== mid_core.sv ====
// Instruction decoder and executer for a small 8-bit core.
// Assumes the fetch path holds each word on insn_in while insn_req_out is high,
// and a file register store that answers a read one clock after freg_rd_out.
`timescale 1ns/1ps
`default_nettype none
`include "mid_defs.svh"
//
// Contract
// - Each 14-bit word splits into an opcode and operand fields.
// - Bit 7 of byte operations sends the result to accumulator or register.
// - File address field is seven bits, 0x00 to 0x7F.
// - Bit operations carry a three-bit position and a seven-bit address.
// - Literals are 8-bit; call and jump carry 11-bit targets, two cycles.
// - Each instruction cycle spans exactly four clock periods.
// - Taken skips and flow changes add a second no-operation cycle.
// - A named register is read, modified, then stored, even if only written.
// - Prefix 00 selectors OR, AND, XOR, add, subtract; flags as listed.
// - Rotates touch carry only; swap; complement, step and copy touch zero.
// - Step down or up, skip on zero result; no flags change.
// - Don't-cares ignored; clear register or accumulator; store accumulator; nop.
// - Prefix 01: clear bit, set bit, skip if clear, skip if set.
// - Prefix 11 literal add, subtract, AND, OR, move with listed flags.
// - Return with literal, return, interrupt return take two cycles.
// - Watchdog kick and standby are one cycle and update both status flags.
// - Standby with watchdog on clears sleep flag, sets expiry flag, clears watchdog.
// - Port registers read pin levels during read-modify-write.
// - Write-back to the timer zero count clears its assigned prescaler.
module mid_core (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Fetch path.
  input wire logic [13:0] insn_in,
  output logic insn_req_out,
  // File register store.
  output logic [6:0] freg_addr_out,
  output logic freg_rd_out,
  input wire logic [7:0] freg_rdata_in,
  input wire logic freg_is_port_in,
  input wire logic [7:0] pin_level_in,
  output logic freg_we_out,
  output logic [7:0] freg_wdata_out,
  // Program flow.
  output logic pc_load_out,
  output logic [10:0] pc_target_out,
  output logic stack_push_out,
  output logic stack_pop_out,
  output logic iret_out,
  output logic flush_out,
  // Datapath state.
  output logic [7:0] acc_out,
  output logic carry_out,
  output logic nibble_overflow_out,
  output logic zero_out,
  // Watchdog, standby and timer.
  input wire logic wdt_enable_in,
  input wire logic prescaler_assigned_in,
  output logic watchdog_expiry_flag_out,
  output logic sleep_entered_flag_out,
  output logic wdt_clear_out,
  output logic standby_out,
  output logic prescaler_clear_out
);
  // --------------------------------------------------------------------------
  // Decode and execute
  // --------------------------------------------------------------------------
  logic [1:0] q_reg;
  logic [13:0] insn_reg;
  mid_pkg::mid_op_e op;
  logic file_op;
  logic [7:0] fval;
  logic [7:0] res;
  logic alu_c;
  logic alu_nib;
  logic alu_z;
  logic upd_c;
  logic upd_nib;
  logic upd_z;
  logic dest_file;
  logic dest_acc;
  logic skip_take;
  logic branch;
  logic taken;
  logic exec;

  mid_decode u_decode (
    .word_in(insn_reg),
    .op_out(op),
    .file_op_out(file_op)
  );

  // Port registers feed back the pin levels, not the output latches.
  assign fval = freg_is_port_in ? pin_level_in : freg_rdata_in;

  mid_alu u_alu (
    .op_in(op),
    .acc_in(acc_out),
    .fval_in(fval),
    .word_in(insn_reg),
    .carry_in(carry_out),
    .res_out(res),
    .c_out(alu_c),
    .nib_out(alu_nib),
    .z_out(alu_z),
    .upd_c_out(upd_c),
    .upd_nib_out(upd_nib),
    .upd_z_out(upd_z)
  );

  assign exec = (q_reg == `MID_Q_LAST);

  // Destination and sequencing decisions for the current word.
  always_comb
  begin
    dest_file = 1'b0;
    dest_acc = 1'b0;
    skip_take = 1'b0;
    branch = 1'b0;
    case (op)
      mid_pkg::op_store_accumulator, mid_pkg::op_zero_register,
      mid_pkg::op_bit_clear_op, mid_pkg::op_bit_set_op: dest_file = 1'b1;
      mid_pkg::op_zero_accumulator, mid_pkg::op_sum_const_into_acc,
      mid_pkg::op_const_minus_acc, mid_pkg::op_conjoin_const_acc,
      mid_pkg::op_disjoin_const_acc, mid_pkg::op_load_const_acc: dest_acc = 1'b1;
      mid_pkg::op_return_with_const:
      begin
        dest_acc = 1'b1;
        branch = 1'b1;
      end
      mid_pkg::op_call, mid_pkg::op_jump, mid_pkg::op_return,
      mid_pkg::op_interrupt_return: branch = 1'b1;
      mid_pkg::op_skip_if_bit_low: skip_take = ~fval[insn_reg[9:7]];
      mid_pkg::op_skip_if_bit_high: skip_take = fval[insn_reg[9:7]];
      mid_pkg::op_nop, mid_pkg::op_watchdog_kick, mid_pkg::op_standby:
        dest_file = 1'b0;
      default:
      begin
        dest_file = insn_reg[`MID_DEST_POS]; // One: back into the register.
        dest_acc = ~insn_reg[`MID_DEST_POS]; // Zero: into the accumulator.
        if (op == mid_pkg::op_step_down_skip_on_nil
            || op == mid_pkg::op_step_up_skip_on_nil)
          skip_take = (res == 8'h00);
      end
    endcase
  end
  assign taken = skip_take | branch;

  // --------------------------------------------------------------------------
  // Phase sequencer and fetch
  // --------------------------------------------------------------------------
  // Four phases per instruction cycle; the word is taken at the end of phase 0.
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      q_reg <= `MID_Q_FIRST;
      insn_req_out <= 1'b0;
    end
    else
    begin
      q_reg <= q_reg + 2'h1;
      insn_req_out <= (q_reg == `MID_Q_LAST);
    end
  end

  // A flushed cycle executes a no-operation in place of the fetched word.
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      insn_reg <= `MID_NOP_WORD;
      flush_out <= `MID_RST_FLAG;
    end
    else
    begin
      if (q_reg == `MID_Q_FIRST)
        insn_reg <= flush_out ? `MID_NOP_WORD : insn_in;
      if (exec)
        flush_out <= taken;
    end
  end

  // --------------------------------------------------------------------------
  // File register access
  // --------------------------------------------------------------------------
  // Read in phase 2, modify in phase 3, write in phase 0 of the next cycle.
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      freg_addr_out <= 7'h00;
      freg_rd_out <= 1'b0;
    end
    else
    begin
      if (q_reg == `MID_Q_READ)
        freg_addr_out <= insn_reg[6:0];
      freg_rd_out <= (q_reg == `MID_Q_READ) && file_op; // Even for pure writes.
    end
  end

  // The write stands for one clock, in phase 0, with the address still held.
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      freg_we_out <= 1'b0;
      freg_wdata_out <= 8'h00;
      prescaler_clear_out <= 1'b0;
    end
    else
    begin
      freg_we_out <= exec && dest_file;
      prescaler_clear_out <= exec && dest_file && prescaler_assigned_in
                             && insn_reg[6:0] == `MID_TIMER_ZERO_ADDR;
      if (exec && dest_file)
        freg_wdata_out <= res;
    end
  end

  // --------------------------------------------------------------------------
  // Accumulator and flags
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      acc_out <= `MID_RST_ACC;
      carry_out <= `MID_RST_FLAG;
      nibble_overflow_out <= `MID_RST_FLAG;
      zero_out <= `MID_RST_FLAG;
    end
    else if (exec)
    begin
      if (dest_acc)
        acc_out <= res;
      if (upd_c)
        carry_out <= alu_c;
      if (upd_nib)
        nibble_overflow_out <= alu_nib;
      if (upd_z)
        zero_out <= alu_z;
    end
  end

  // --------------------------------------------------------------------------
  // Program flow
  // --------------------------------------------------------------------------
  // Pulses stand for phase 0 of the cycle after the instruction.
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      pc_load_out <= 1'b0;
      pc_target_out <= 11'h000;
      stack_push_out <= 1'b0;
      stack_pop_out <= 1'b0;
      iret_out <= 1'b0;
    end
    else
    begin
      pc_load_out <= exec && (op == mid_pkg::op_call || op == mid_pkg::op_jump);
      stack_push_out <= exec && op == mid_pkg::op_call;
      stack_pop_out <= exec && (op == mid_pkg::op_return || op == mid_pkg::op_interrupt_return
                                || op == mid_pkg::op_return_with_const);
      iret_out <= exec && op == mid_pkg::op_interrupt_return;
      if (exec && (op == mid_pkg::op_call || op == mid_pkg::op_jump))
        pc_target_out <= insn_reg[10:0];
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog and standby
  // --------------------------------------------------------------------------
  // Both status bits read one after reset, as on power-up.
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      watchdog_expiry_flag_out <= `MID_RST_STATUS_HI;
      sleep_entered_flag_out <= `MID_RST_STATUS_HI;
      wdt_clear_out <= 1'b0;
      standby_out <= 1'b0;
    end
    else
    begin
      wdt_clear_out <= exec && (op == mid_pkg::op_watchdog_kick
                       || (op == mid_pkg::op_standby && wdt_enable_in));
      standby_out <= exec && op == mid_pkg::op_standby;
      if (exec && op == mid_pkg::op_watchdog_kick)
      begin
        watchdog_expiry_flag_out <= 1'b1;
        sleep_entered_flag_out <= 1'b1;
      end
      else if (exec && op == mid_pkg::op_standby)
      begin
        watchdog_expiry_flag_out <= 1'b1;
        sleep_entered_flag_out <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_taken;
    exec && taken;
  endsequence
  sequence s_nop_cycle;
    flush_out [*4] ##1 !flush_out;
  endsequence

  property p_cycle_four;
    insn_req_out |=> !insn_req_out [*3] ##1 insn_req_out;
  endproperty
  a_cycle_four: assert property (p_cycle_four) else $error("cycle not four clocks");

  property p_flush_one_cycle;
    s_taken |=> s_nop_cycle;
  endproperty
  a_flush_one_cycle: assert property (p_flush_one_cycle) else $error("bad flush");

  property p_read_first;
    freg_we_out |-> $past(freg_rd_out, 2);
  endproperty
  a_read_first: assert property (p_read_first) else $error("write without read");

  property p_acc_dest;
    exec && file_op && !dest_file |=> !freg_we_out;
  endproperty
  a_acc_dest: assert property (p_acc_dest) else $error("acc result written");

  property p_addr_field;
    freg_rd_out |-> freg_addr_out == insn_reg[6:0];
  endproperty
  a_addr_field: assert property (p_addr_field) else $error("address mismatch");

  property p_call_target;
    exec && op == mid_pkg::op_call |=> stack_push_out && pc_load_out
      && pc_target_out == $past(insn_reg[10:0]);
  endproperty
  a_call_target: assert property (p_call_target) else $error("call target wrong");

  property p_skip_no_flags;
    exec && op == mid_pkg::op_step_down_skip_on_nil
      |=> $stable({carry_out, nibble_overflow_out, zero_out});
  endproperty
  a_skip_no_flags: assert property (p_skip_no_flags) else $error("skip moved flags");

  property p_standby;
    exec && op == mid_pkg::op_standby && wdt_enable_in
      |=> wdt_clear_out && !sleep_entered_flag_out && watchdog_expiry_flag_out;
  endproperty
  a_standby: assert property (p_standby) else $error("standby flags wrong");

  property p_prescaler;
    prescaler_clear_out |-> freg_we_out && freg_addr_out == `MID_TIMER_ZERO_ADDR;
  endproperty
  a_prescaler: assert property (p_prescaler) else $error("stray prescaler clear");

  property p_nop_quiet;
    exec && op == mid_pkg::op_nop |=> !freg_we_out && !pc_load_out && $stable(acc_out);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("nop changed state");
endmodule
`default_nettype wire

// ==== mid_defs.svh ====
// Constants for the mid-range instruction decoder: phases, fixed words, reset values.
// Assumes inclusion by bare name from the design files that need them.
`ifndef MID_DEFS_SVH
`define MID_DEFS_SVH
// ----------------------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------------------
// One instruction cycle spans four clock periods, counted 0 to 3.
`define MID_Q_FIRST 2'h0
`define MID_Q_READ 2'h1
`define MID_Q_LAST 2'h3
// ----------------------------------------------------------------------------
// Instruction word fields and fixed words
// ----------------------------------------------------------------------------
`define MID_DEST_POS 7
`define MID_NOP_WORD 14'h0000
`define MID_KICK_WORD 14'h0064
`define MID_STANDBY_WORD 14'h0063
`define MID_RETURN_WORD 14'h0008
`define MID_IRET_WORD 14'h0009
// File address of the timer zero count register.
`define MID_TIMER_ZERO_ADDR 7'h01
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MID_RST_ACC 8'h00
`define MID_RST_FLAG 1'b0
`define MID_RST_STATUS_HI 1'b1
`endif

// ==== mid_pkg.sv ====
// Types shared by the mid-range instruction decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package mid_pkg;
  // Every operation the decoder distinguishes; unlisted words map to op_nop.
  typedef enum logic [5:0] {
    op_nop, op_sum_acc_into_reg, op_conjoin_acc_reg, op_disjoin_acc_reg,
    op_exclusive_disjoin_acc_reg, op_reg_minus_acc, op_rotate_up_via_carry,
    op_rotate_down_via_carry, op_nibble_exchange, op_invert_register,
    op_step_down_register, op_step_up_register, op_copy_register,
    op_step_down_skip_on_nil, op_step_up_skip_on_nil, op_zero_register,
    op_zero_accumulator, op_store_accumulator, op_bit_clear_op, op_bit_set_op,
    op_skip_if_bit_low, op_skip_if_bit_high, op_sum_const_into_acc,
    op_const_minus_acc, op_conjoin_const_acc, op_disjoin_const_acc,
    op_load_const_acc, op_return_with_const, op_call, op_jump, op_return,
    op_interrupt_return, op_watchdog_kick, op_standby
  } mid_op_e;
endpackage

// ==== mid_decode.sv ====
// Instruction word classifier for the mid-range decoder.
// Assumes a stable 14-bit word; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "mid_defs.svh"
module mid_decode (
  // Word under decode.
  input wire logic [13:0] word_in,
  // Operation and whether it names a file register.
  output mid_pkg::mid_op_e op_out,
  output logic file_op_out
);
  // Don't-care bits are never looked at, so every legal spelling decodes alike.
  always_comb
  begin
    op_out = mid_pkg::op_nop; // Unknown words fall through as no-operations.
    file_op_out = 1'b0;
    case (word_in[13:12]) // Opcode portion first, operands qualify it.
      2'b00:
      begin
        file_op_out = 1'b1;
        case (word_in[11:8]) // Byte selectors.
          4'h7: op_out = mid_pkg::op_sum_acc_into_reg;
          4'h5: op_out = mid_pkg::op_conjoin_acc_reg;
          4'h4: op_out = mid_pkg::op_disjoin_acc_reg;
          4'h6: op_out = mid_pkg::op_exclusive_disjoin_acc_reg;
          4'h2: op_out = mid_pkg::op_reg_minus_acc;
          4'hD: op_out = mid_pkg::op_rotate_up_via_carry;
          4'hC: op_out = mid_pkg::op_rotate_down_via_carry;
          4'hE: op_out = mid_pkg::op_nibble_exchange;
          4'h9: op_out = mid_pkg::op_invert_register;
          4'h3: op_out = mid_pkg::op_step_down_register;
          4'hA: op_out = mid_pkg::op_step_up_register;
          4'h8: op_out = mid_pkg::op_copy_register;
          4'hB: op_out = mid_pkg::op_step_down_skip_on_nil;
          4'hF: op_out = mid_pkg::op_step_up_skip_on_nil;
          4'h1: op_out = word_in[7] ? mid_pkg::op_zero_register
                                    : mid_pkg::op_zero_accumulator;
          default:
          begin
            file_op_out = word_in[7];
            if (word_in[7])
              op_out = mid_pkg::op_store_accumulator;
            else if (word_in == `MID_KICK_WORD)
              op_out = mid_pkg::op_watchdog_kick;
            else if (word_in == `MID_STANDBY_WORD)
              op_out = mid_pkg::op_standby;
            else if (word_in == `MID_RETURN_WORD)
              op_out = mid_pkg::op_return;
            else if (word_in == `MID_IRET_WORD)
              op_out = mid_pkg::op_interrupt_return;
          end
        endcase
        if (op_out == mid_pkg::op_zero_accumulator)
          file_op_out = 1'b0;
      end
      2'b01:
      begin
        file_op_out = 1'b1;
        case (word_in[11:10]) // Bit operations.
          2'b00: op_out = mid_pkg::op_bit_clear_op;
          2'b01: op_out = mid_pkg::op_bit_set_op;
          2'b10: op_out = mid_pkg::op_skip_if_bit_low;
          default: op_out = mid_pkg::op_skip_if_bit_high;
        endcase
      end
      2'b10: op_out = word_in[11] ? mid_pkg::op_jump : mid_pkg::op_call;
      default:
      begin
        case (word_in[11:8]) // Literal operations.
          4'hE, 4'hF: op_out = mid_pkg::op_sum_const_into_acc;
          4'hC, 4'hD: op_out = mid_pkg::op_const_minus_acc;
          4'h9: op_out = mid_pkg::op_conjoin_const_acc;
          4'h8: op_out = mid_pkg::op_disjoin_const_acc;
          4'h0, 4'h1, 4'h2, 4'h3: op_out = mid_pkg::op_load_const_acc;
          4'h4, 4'h5, 4'h6, 4'h7: op_out = mid_pkg::op_return_with_const;
          default: op_out = mid_pkg::op_nop;
        endcase
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== mid_alu.sv ====
// Arithmetic and logic unit for the mid-range decoder.
// Assumes operands stable for the cycle; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module mid_alu (
  // Operation and operands.
  input wire mid_pkg::mid_op_e op_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] fval_in,
  input wire logic [13:0] word_in,
  input wire logic carry_in,
  // Result and flags, each with its update enable.
  output logic [7:0] res_out,
  output logic c_out,
  output logic nib_out,
  output logic z_out,
  output logic upd_c_out,
  output logic upd_nib_out,
  output logic upd_z_out
);
  // Returns {carry, nibble carry, sum}; a subtract is a plus inverted plus one.
  function automatic logic [9:0] add_bytes(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction

  logic [9:0] sum;
  logic [7:0] lit;
  logic [7:0] mask;
  assign lit = word_in[7:0];
  assign mask = 8'h01 << word_in[9:7]; // Three-bit position within the byte.

  // Result and flag selection per operation.
  always_comb
  begin
    sum = 10'h000;
    res_out = fval_in;
    c_out = carry_in;
    nib_out = 1'b0;
    upd_c_out = 1'b0;
    upd_nib_out = 1'b0;
    upd_z_out = 1'b1;
    case (op_in)
      mid_pkg::op_sum_acc_into_reg: sum = add_bytes(fval_in, acc_in, 1'b0);
      mid_pkg::op_reg_minus_acc: sum = add_bytes(fval_in, ~acc_in, 1'b1);
      mid_pkg::op_sum_const_into_acc: sum = add_bytes(lit, acc_in, 1'b0);
      mid_pkg::op_const_minus_acc: sum = add_bytes(lit, ~acc_in, 1'b1);
      mid_pkg::op_conjoin_acc_reg: res_out = acc_in & fval_in;
      mid_pkg::op_disjoin_acc_reg: res_out = acc_in | fval_in;
      mid_pkg::op_exclusive_disjoin_acc_reg: res_out = acc_in ^ fval_in;
      mid_pkg::op_conjoin_const_acc: res_out = acc_in & lit;
      mid_pkg::op_disjoin_const_acc: res_out = acc_in | lit;
      mid_pkg::op_invert_register: res_out = ~fval_in;
      mid_pkg::op_step_down_register: res_out = fval_in - 8'h01;
      mid_pkg::op_step_up_register: res_out = fval_in + 8'h01;
      mid_pkg::op_copy_register: res_out = fval_in;
      mid_pkg::op_zero_register, mid_pkg::op_zero_accumulator: res_out = 8'h00;
      default: upd_z_out = 1'b0;
    endcase
    case (op_in)
      mid_pkg::op_sum_acc_into_reg, mid_pkg::op_reg_minus_acc,
      mid_pkg::op_sum_const_into_acc, mid_pkg::op_const_minus_acc:
      begin
        res_out = sum[7:0];
        c_out = sum[9];
        nib_out = sum[8];
        upd_c_out = 1'b1;
        upd_nib_out = 1'b1;
      end
      mid_pkg::op_rotate_up_via_carry:
      begin
        res_out = {fval_in[6:0], carry_in}; // Carry only.
        c_out = fval_in[7];
        upd_c_out = 1'b1;
      end
      mid_pkg::op_rotate_down_via_carry:
      begin
        res_out = {carry_in, fval_in[7:1]};
        c_out = fval_in[0];
        upd_c_out = 1'b1;
      end
      mid_pkg::op_nibble_exchange: res_out = {fval_in[3:0], fval_in[7:4]};
      mid_pkg::op_step_down_skip_on_nil: res_out = fval_in - 8'h01; // No flags.
      mid_pkg::op_step_up_skip_on_nil: res_out = fval_in + 8'h01;
      mid_pkg::op_store_accumulator: res_out = acc_in;
      mid_pkg::op_bit_clear_op: res_out = fval_in & ~mask;
      mid_pkg::op_bit_set_op: res_out = fval_in | mask;
      mid_pkg::op_load_const_acc, mid_pkg::op_return_with_const: res_out = lit;
      default: sum = 10'h000;
    endcase
    z_out = (res_out == 8'h00);
  end
endmodule
`default_nettype wire

// ==== mid_fstore.sv ====
// File register store model facing the decoder core.
// Assumes read strobes want data one clock later and writes land at the edge.
`timescale 1ns/1ps
`default_nettype none
module mid_fstore (
  // Core side.
  input wire logic mclk_in,
  input wire logic [6:0] addr_in,
  input wire logic rd_in,
  input wire logic we_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic is_port_out
);
  logic [7:0] mem [128];
  // Each cell starts at its own address, so reads are easy to predict.
  initial foreach (mem[i]) mem[i] = 8'(i);
  // Outside an answer the bus toggles each clock, so the stale read data comes back on every second clock.
  always @(posedge mclk_in) rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
  always @(posedge mclk_in) if (we_in) mem[addr_in] <= wdata_in;
  // Address 0x05 stands for a pin port; it follows the held address as a level.
  assign is_port_out = (addr_in == 7'h05);
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the decoder core beside its file store model.
// Assumes the design files and the store model are compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [13:0] insn_in = 14'h0000;
  logic insn_req_out, freg_rd_out, freg_we_out, freg_is_port_in, carry_out, zero_out;
  logic watchdog_expiry_flag_out, sleep_entered_flag_out;
  logic pc_load_out, stack_push_out, stack_pop_out, iret_out, flush_out, nibble_overflow_out;
  logic wdt_clear_out, standby_out, prescaler_clear_out, wdt_en = 1'b1;
  logic [10:0] pc_target_out, tgt = 11'h000;
  // Pulse counters, bumped mid-cycle where the pulses are settled; the four-clock flush_out counts four.
  logic [7:0] n_load = 8'h00, n_push = 8'h00, n_pop = 8'h00, n_iret = 8'h00;
  logic [7:0] n_flush = 8'h00, n_wdt = 8'h00, n_stby = 8'h00, n_pre = 8'h00;
  logic [6:0] freg_addr_out;
  logic [7:0] freg_rdata_in, freg_wdata_out, acc_out, mem20;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  // Rows pack word, accumulator, register 0x20, carry and zero; state carries over.
  logic [31:0] rows [23] = '{32'hC3C3C080, 32'h1E83C042, 32'h14804042, 32'h18800043,
    32'h10804042, 32'h0A804003, 32'h2A804006, 32'h30820006, 32'h3682000C, 32'h3A8200C0,
    32'h24833CC0, 32'h0E833CBC, 32'h2080BCBC, 32'h0680BC01, 32'h0280BCBD, 32'h040000BD,
    32'hFBFFFCBC, 32'hE43C3CBC, 32'hE0C0FCBC, 32'hF0FC00BF, 32'h588000FF, 32'h488000BF,
    32'hE95400BF};
  // Design under test and its file store; the pins read back a fixed level.
  mid_core mid_core_i (.mclk_in, .nrst_in, .insn_in, .insn_req_out, .freg_addr_out,
    .freg_rd_out, .freg_rdata_in, .freg_is_port_in, .pin_level_in(8'h5A), .freg_we_out,
    .freg_wdata_out, .pc_load_out, .pc_target_out, .stack_push_out, .stack_pop_out,
    .iret_out, .flush_out, .acc_out, .carry_out, .nibble_overflow_out, .zero_out,
    .wdt_enable_in(wdt_en), .prescaler_assigned_in(1'b1), .watchdog_expiry_flag_out,
    .sleep_entered_flag_out, .wdt_clear_out, .standby_out, .prescaler_clear_out);
  mid_fstore mid_fstore_i (.mclk_in, .addr_in(freg_addr_out), .rd_in(freg_rd_out),
    .we_in(freg_we_out), .wdata_in(freg_wdata_out), .rdata_out(freg_rdata_in),
    .is_port_out(freg_is_port_in));
  // Clock, a cap on run length well above the few hundred cycles needed, a register view.
  always #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (++cycles == 1000) report_and_stop(1);
  assign mem20 = mid_fstore_i.mem[7'h20];
  // Counting at the falling edge keeps the tally clear of the launching edge.
  always @(negedge mclk_in)
  begin
    n_load <= n_load + 8'(pc_load_out);
    n_push <= n_push + 8'(stack_push_out);
    n_pop <= n_pop + 8'(stack_pop_out);
    n_iret <= n_iret + 8'(iret_out);
    n_flush <= n_flush + 8'(flush_out);
    n_wdt <= n_wdt + 8'(wdt_clear_out);
    n_stby <= n_stby + 8'(standby_out);
    n_pre <= n_pre + 8'(prescaler_clear_out);
    if (pc_load_out) tgt <= pc_target_out;
  end
  // Compares one value and keeps the counts.
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    err_total += (seen !== want);
    if (seen !== want) $display("Error at %0t: seen %h expected %h", $time, seen, want);
  endtask
  // Feeds two words then two fillers, one per fetch slot, and lets the results land.
  task automatic run(input logic [13:0] a, input logic [13:0] b);
    logic [13:0] seq [4] = '{a, b, 14'h0000, 14'h0000};
    foreach (seq[i])
    begin
      do @(posedge mclk_in); while (insn_req_out !== 1'b1);
      insn_in <= seq[i];
    end
    #1;
  endtask
  // Ends the run with the counts and the verdict.
  task automatic report_and_stop(input int extra);
    err_total += extra;
    $display("Comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Reset, then the table, then the cases that depend on order.
  initial
  begin
    repeat (10) @(posedge mclk_in);
    nrst_in <= 1'b1;
    #1;
    check(acc_out, 8'h00);
    check({6'h00, watchdog_expiry_flag_out, sleep_entered_flag_out}, 8'h03);
    $display("Reset test done");
    foreach (rows[i])
    begin
      run(rows[i][31:18], 14'h0000);
      check(acc_out, rows[i][17:10]);
      check(mem20, rows[i][9:2]);
      check({6'h00, carry_out, zero_out}, {6'h00, rows[i][1:0]});
    end
    $display("Table test done");
    // A taken skip drops the next word; an untaken one lets it run.
    run(14'h1C20, 14'h3055);
    check(acc_out, 8'h00);
    run(14'h1820, 14'h3077);
    check(acc_out, 8'h77);
    run(14'h0805, 14'h0000);
    check(acc_out, 8'h5A);
    run(14'h0063, 14'h0000);
    check({6'h00, watchdog_expiry_flag_out, sleep_entered_flag_out}, 8'h02);
    run(14'h0064, 14'h0000);
    check({6'h00, watchdog_expiry_flag_out, sleep_entered_flag_out}, 8'h03);
    check(n_wdt, 8'h02);
    wdt_en <= 1'b0;
    run(14'h0063, 14'h0000);
    check(n_wdt, 8'h02);
    check(n_stby, 8'h02);
    // Stepping register 0x01 down to zero skips the load, keeps flags, clears the prescaler.
    run(14'h0B81, 14'h3011);
    check(acc_out, 8'h5A);
    check({6'h00, carry_out, zero_out}, 8'h02);
    check(n_pre, 8'h01);
    run(14'h3E0F, 14'h0000);
    check({5'h00, nibble_overflow_out, carry_out, zero_out}, 8'h04);
    run(14'h2123, 14'h0000);
    check(tgt[7:0], 8'h23);
    run(14'h2ABC, 14'h0000);
    check(tgt[10:3], 8'h57);
    check({n_push[3:0], n_load[3:0]}, 8'h12);
    run(14'h0008, 14'h0000);
    run(14'h0009, 14'h0000);
    run(14'h3455, 14'h0000);
    check(acc_out, 8'h55);
    check({n_pop[3:0], n_iret[3:0]}, 8'h31);
    check(n_flush, 8'h1C);
    $display("Awkward test done");
    report_and_stop(0);
  end
endmodule
`default_nettype wire
